// ===== verilog/sdp_port.sv
// One port of a synchronous dual-port static RAM with burst address counter.
// Assumes the host runs on mclk_i and drives the data pin from data_oe_o.
//
// Overview of operation
// [RULE_01] Every input register captures on the port clock rising edge; write is self-timed.
// [RULE_02] Internal address is the external address when strobe low, else the counter.
// [RULE_03] Strobe held low loads a new address every edge; any order allowed.
// [RULE_04] Output drive state follows the controls sampled in the previous cycle; in pipelined mode the code drives from read controls two cycles back.
// [RULE_05] Counter clear resets counter with no dead cycle; that access hits address zero.
// [RULE_06] Counter advance low increments the internal address by one each edge.
// [RULE_07] Write burst with advance writes data to the incremented address that cycle.
// [RULE_08] Output enable gates the data drivers asynchronously.
// [RULE_09] Port powers down after chip-enable pair deselected for one cycle.
// [RULE_10] Pipelined mode needs two selected cycles before outputs drive again.
// [RULE_11] Host decodes chip enables so only one bank is selected at a time.
// [RULE_12] Strobe high and advance high: address holds, read data stays constant.
// [RULE_13] Port runs address, counter and control registers from its own clock only.
`timescale 1ns/10ps

module sdp_port
    import sdp_pkg::*;
(
    // Clock and reset
    input  wire logic              mclk_i,
    input  wire logic              srst_i,
    // Host side pins
    input  wire sdp_ctrl_s         ctrl_i,
    input  wire logic              out_en_n_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] data_i,
    // Data pin drive and status
    output logic [DATA_W-1:0]      data_o,
    output logic [LANES-1:0]       data_oe_o,
    output logic                   powered_down_o
);

    sdp_state_s        state_reg;
    sdp_state_s        state_next;
    logic              sel;
    logic [ADDR_W-1:0] addr_eff;
    logic [LANES-1:0]  lane_en;
    logic [LANES-1:0]  rd_lanes;
    logic [LANES-1:0]  wr_lanes;
    logic [DATA_W-1:0] rd_data;

    // Select is low-active enable low with high-active enable high
    assign sel     = ~ctrl_i.chip_sel_low_active & ctrl_i.chip_sel_high_active;
    assign lane_en = ~{ctrl_i.upper_byte_sel_n, ctrl_i.lower_byte_sel_n};
    assign rd_lanes = {LANES{sel & ctrl_i.read_not_write}} & lane_en;
    assign wr_lanes = {LANES{sel & ~ctrl_i.read_not_write}} & lane_en;

    // Internal address: clear, load, advance, or hold
    always_comb begin
        if (!ctrl_i.counter_clear_n) begin
            addr_eff = ADDR_ZERO; // RULE_05
        end else if (!ctrl_i.addr_load_strobe_n) begin
            addr_eff = addr_i; // RULE_02 RULE_03
        end else if (!ctrl_i.counter_advance_n) begin
            addr_eff = state_reg.cnt + CNT_STEP; // RULE_06 RULE_07
        end else begin
            addr_eff = state_reg.cnt; // RULE_12
        end
    end

    // Memory array, one bank per byte lane; write completes within the edge
    generate
        for (genvar g = 0; g < LANES; g++) begin : g_lane
            logic [LANE_W-1:0] mem [DEPTH];

            always_ff @(posedge mclk_i) begin
                if (wr_lanes[g]) begin
                    mem[addr_eff] <= data_i[g*LANE_W +: LANE_W]; // RULE_01 RULE_07
                end
            end

            assign rd_data[g*LANE_W +: LANE_W] = mem[addr_eff];
        end
    endgenerate

    // Next state
    always_comb begin
        state_next              = state_reg;
        state_next.cnt          = addr_eff; // RULE_02 RULE_05 RULE_06
        state_next.pipe_data    = rd_data;
        state_next.pipe_drv     = rd_lanes;
        state_next.powered_down = ~sel; // RULE_09
        if (ctrl_i.flow_or_pipe_select) begin
            state_next.out_data = state_reg.pipe_data;
            state_next.out_drv  = state_reg.pipe_drv & {LANES{sel}}; // RULE_10
        end else begin
            state_next.out_data = rd_data;
            state_next.out_drv  = rd_lanes; // RULE_04
        end
    end

    // Single clock domain for the whole port
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            state_reg.cnt          <= ADDR_ZERO;
            state_reg.pipe_data    <= DATA_ZERO;
            state_reg.pipe_drv     <= LANES_OFF;
            state_reg.out_data     <= DATA_ZERO;
            state_reg.out_drv      <= LANES_OFF;
            state_reg.powered_down <= 1'b1;
        end else begin
            state_reg <= state_next; // RULE_01 RULE_13
        end
    end

    assign data_o         = state_reg.out_data;
    assign data_oe_o      = state_reg.out_drv & {LANES{~out_en_n_i}}; // RULE_08
    assign powered_down_o = state_reg.powered_down;

    // Checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);

    // Terms shared by the checks below
    logic              hold_cmd;
    logic              rd_any;
    logic              wr_any;
    logic              pipe_mode;

    assign hold_cmd  = ctrl_i.addr_load_strobe_n & ctrl_i.counter_advance_n
                       & ctrl_i.counter_clear_n;
    assign rd_any    = |rd_lanes;
    assign wr_any    = |wr_lanes;
    assign pipe_mode = ctrl_i.flow_or_pipe_select;

    // Address counter
    a_addr_load: assert property ( // RULE_02
        (!ctrl_i.addr_load_strobe_n && ctrl_i.counter_clear_n)
        |=> state_reg.cnt == $past(addr_i))
        else $error("Strobe low did not load the external address");

    a_counter_clear: assert property ( // RULE_05
        !ctrl_i.counter_clear_n |=> state_reg.cnt == ADDR_ZERO)
        else $error("Counter clear did not reach address zero");

    a_counter_step: assert property ( // RULE_06
        (ctrl_i.addr_load_strobe_n && !ctrl_i.counter_advance_n && ctrl_i.counter_clear_n)
        |=> state_reg.cnt == ADDR_W'($past(state_reg.cnt) + CNT_STEP))
        else $error("Counter advance did not step by one");

    a_counter_hold: assert property ( // RULE_12
        (ctrl_i.addr_load_strobe_n && ctrl_i.counter_advance_n && ctrl_i.counter_clear_n)
        |=> $stable(state_reg.cnt))
        else $error("Address moved while strobe and advance were high");

    a_addr_used: assert property ( // RULE_02
        (!ctrl_i.addr_load_strobe_n && ctrl_i.counter_clear_n) |-> addr_eff == addr_i)
        else $error("Strobe low access did not use the external address");

    a_clear_access: assert property ( // RULE_05
        !ctrl_i.counter_clear_n |-> addr_eff == ADDR_ZERO)
        else $error("Clear cycle access did not hit address zero");

    a_flow_drive: assert property ( // RULE_04
        !ctrl_i.flow_or_pipe_select |=> state_reg.out_drv == $past(rd_lanes))
        else $error("Flow mode drive not set by previous cycle controls");

    // Read data path and output enable
    a_flow_data: assert property ( // RULE_04
        (rd_any && !pipe_mode) |=> data_o == $past(rd_data))
        else $error("Flow mode read data not taken from the addressed word");

    a_pipe_data: assert property ( // RULE_04
        pipe_mode |=> data_o == $past(state_reg.pipe_data))
        else $error("Pipelined read data skipped its second stage");

    a_write_quiet: assert property ( // RULE_04
        (wr_any && !pipe_mode) |=> state_reg.out_drv == LANES_OFF)
        else $error("Write cycle turned on the output drivers");

    a_out_hold: assert property ( // RULE_12
        (hold_cmd && rd_any && !pipe_mode) ##1 (hold_cmd && rd_any && !pipe_mode)
        |=> $stable(data_o))
        else $error("Read data moved while the address was held");

    a_oe_gate: assert property ( // RULE_08
        out_en_n_i |-> data_oe_o == LANES_OFF)
        else $error("Output enable high left a lane driving");

    a_oe_follow: assert property ( // RULE_08
        !out_en_n_i |-> data_oe_o == state_reg.out_drv)
        else $error("Output enable low did not pass the lane drive");

    a_power_down: assert property ( // RULE_09
        !sel |=> powered_down_o ##0 state_reg.out_drv == LANES_OFF)
        else $error("Deselected port did not power down");

    // Power state and wake-up
    a_drive_up: assert property ( // RULE_09
        sel |=> !powered_down_o)
        else $error("Selected port stayed powered down");

    a_pd_quiet: assert property ( // RULE_09
        powered_down_o |-> state_reg.out_drv == LANES_OFF)
        else $error("Powered down port still drives a lane");

    a_pipe_wake: assert property ( // RULE_10
        (ctrl_i.flow_or_pipe_select && !sel) ##1 ctrl_i.flow_or_pipe_select
        |=> state_reg.out_drv == LANES_OFF)
        else $error("Pipelined outputs drove within two cycles of deselect");

    a_pipe_read: assert property ( // RULE_04
        (ctrl_i.flow_or_pipe_select && rd_lanes != LANES_OFF)
        ##1 (ctrl_i.flow_or_pipe_select && sel)
        |=> state_reg.out_drv == $past(rd_lanes, 2))
        else $error("Pipelined read did not drive two cycles later");

    // Main scenarios
    c_burst_write: cover property (
        wr_lanes != LANES_OFF && ctrl_i.addr_load_strobe_n && !ctrl_i.counter_advance_n);
    c_clear_read: cover property (
        !ctrl_i.counter_clear_n && rd_lanes != LANES_OFF);
    c_pipe_read: cover property (
        ctrl_i.flow_or_pipe_select && sel ##1 sel ##1 state_reg.out_drv != LANES_OFF);
    c_wake_up: cover property (!sel ##1 sel ##1 sel);
    c_lane_write: cover property (
        wr_any && lane_en != {LANES{1'b1}});

endmodule : sdp_port

// ===== common/sdp_pkg.sv
// Constants, pin bundle and state layout for one synchronous RAM port.
// Assumes a single port clock; the opposite port lives in its own block.
package sdp_pkg;

    localparam int ADDR_W = 14;
    localparam int DATA_W = 18;
    localparam int LANES  = 2;
    localparam int LANE_W = 9;
    localparam int DEPTH  = 16384;

    localparam logic [ADDR_W-1:0] ADDR_ZERO = 14'h0000;
    localparam logic [ADDR_W-1:0] CNT_STEP  = 14'h0001;
    localparam logic [LANES-1:0]  LANES_OFF = 2'h0;
    localparam logic [DATA_W-1:0] DATA_ZERO = 18'h0_0000;

    localparam int LANE_LOW = 0;
    localparam int LANE_UP  = 1;

    // Control pins of the port, sampled on the rising clock edge
    typedef struct packed {
        logic chip_sel_low_active;
        logic chip_sel_high_active;
        logic addr_load_strobe_n;
        logic counter_advance_n;
        logic counter_clear_n;
        logic read_not_write;
        logic upper_byte_sel_n;
        logic lower_byte_sel_n;
        logic flow_or_pipe_select;
    } sdp_ctrl_s;

    // Whole state of the port
    typedef struct packed {
        logic [ADDR_W-1:0] cnt;
        logic [DATA_W-1:0] pipe_data;
        logic [LANES-1:0]  pipe_drv;
        logic [DATA_W-1:0] out_data;
        logic [LANES-1:0]  out_drv;
        logic              powered_down;
    } sdp_state_s;

endpackage : sdp_pkg

// ===== verif/sdp_host.sv
// Host model: drives the port pins at the falling edge, shows the data pin.
// Assumes the bench posts each request just after a rising edge.
`timescale 1ns/10ps
module sdp_host
    import sdp_pkg::*;
(
    // Bench requests
    input  wire logic              mclk_i,
    input  wire sdp_ctrl_s         req_ctrl_i,
    input  wire logic [ADDR_W-1:0] req_addr_i,
    input  wire logic [DATA_W-1:0] req_data_i,
    // Port side
    input  wire logic [DATA_W-1:0] dev_data_i,
    input  wire logic [LANES-1:0]  dev_oe_i,
    output sdp_ctrl_s              ctrl_o,
    output logic [ADDR_W-1:0]      addr_o,
    output logic [DATA_W-1:0]      data_o,
    output logic [DATA_W-1:0]      bus_o
);
    initial {ctrl_o, addr_o, data_o} = '0;
    // Pins change only at the falling edge, any address order
    always @(negedge mclk_i) begin
        ctrl_o <= req_ctrl_i;
        addr_o <= req_addr_i;
        data_o <= req_data_i;
    end
    // Released lanes show the inverse of the last value
    assign bus_o = {dev_oe_i[1] ? dev_data_i[17:9] : ~dev_data_i[17:9],
                    dev_oe_i[0] ? dev_data_i[8:0] : ~dev_data_i[8:0]};
endmodule : sdp_host

// ===== verif/sdp_port_test.sv
// Self-checking bench for one RAM port driven through the host model.
// Assumes sdp_pkg and sdp_host are compiled first.
`timescale 1ns/10ps
module sdp_port_test;
    import sdp_pkg::*;
    typedef struct packed {
        logic [3:0]        k;
        logic [ADDR_W-1:0] a;
        logic [DATA_W-1:0] d;
        logic [DATA_W-1:0] q;
        logic [LANES-1:0]  oe;
    } sdp_row_s;
    logic              mclk_i = 1'b0;
    logic              srst_i = 1'b1;
    logic              oe_n   = 1'b0;
    logic [LANES-1:0]  lanes_n = 2'h0;
    sdp_ctrl_s         rc     = '0;
    logic [ADDR_W-1:0] ra     = 14'h0000;
    logic [DATA_W-1:0] rd     = 18'h0_0000;
    logic [DATA_W-1:0] dq, bus, pdat;
    logic [ADDR_W-1:0] pa;
    logic [LANES-1:0]  doe;
    logic              pd;
    sdp_ctrl_s         pc;
    int                n_mismatch = 0;
    int                total_checks = 0;
    sdp_row_s          rows [11];
    sdp_host host_u (.mclk_i(mclk_i), .req_ctrl_i(rc), .req_addr_i(ra), .req_data_i(rd),
        .dev_data_i(dq), .dev_oe_i(doe), .ctrl_o(pc), .addr_o(pa), .data_o(pdat), .bus_o(bus));
    sdp_port dut_u (.mclk_i(mclk_i), .srst_i(srst_i), .ctrl_i(pc), .out_en_n_i(oe_n),
        .addr_i(pa), .data_i(pdat), .data_o(dq), .data_oe_o(doe), .powered_down_o(pd));
    task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // One cycle: k is strobe_n, advance_n, clear_n, read
    task automatic go(input logic [3:0] k, input logic sel, input logic pipe,
                      input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        rc = '{~sel, sel, k[3], k[2], k[1], k[0], lanes_n[1], lanes_n[0], pipe};
        ra = a;
        rd = d;
        @(posedge mclk_i);
        #1;
    endtask : go
    task automatic end_sim;
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_sim
    initial begin
        forever #5 mclk_i = ~mclk_i;
    end
    initial begin
        #100000;
        n_mismatch++;
        end_sim();
    end
    initial begin
        rows = '{'{4'h6, 14'h0010, 18'h1_2345, 18'h0_0000, 2'h0},
                 '{4'hA, 14'h0000, 18'h2_0001, 18'h0_0000, 2'h0},
                 '{4'hA, 14'h0000, 18'h3_0002, 18'h0_0000, 2'h0},
                 '{4'h7, 14'h0011, 18'h0_0000, 18'h2_0001, 2'h3},
                 '{4'h7, 14'h0010, 18'h0_0000, 18'h1_2345, 2'h3},
                 '{4'hB, 14'h0000, 18'h0_0000, 18'h2_0001, 2'h3},
                 '{4'hF, 14'h0000, 18'h0_0000, 18'h2_0001, 2'h3},
                 '{4'hC, 14'h0000, 18'h0_0ABC, 18'h0_0000, 2'h0},
                 '{4'hF, 14'h0000, 18'h0_0000, 18'h0_0ABC, 2'h3},
                 '{4'h7, 14'h0012, 18'h0_0000, 18'h3_0002, 2'h3},
                 '{4'hD, 14'h0010, 18'h0_0000, 18'h0_0ABC, 2'h3}};
        repeat (16) @(negedge mclk_i);
        chk(pd, 1'b1);
        chk(doe, 2'h0);
        srst_i = 1'b0;
        @(posedge mclk_i);
        #1;
        foreach (rows[i]) begin
            go(rows[i].k, 1'b1, 1'b0, rows[i].a, rows[i].d);
            chk(doe, rows[i].oe);
            if (rows[i].oe != 2'h0) begin
                chk(bus, rows[i].q);
            end
        end
        go(4'hF, 1'b0, 1'b0, 14'h0000, 18'h0_0000);
        chk(pd, 1'b1);
        chk(doe, 2'h0);
        go(4'h7, 1'b1, 1'b1, 14'h0010, 18'h0_0000);
        chk(pd, 1'b0);
        chk(doe, 2'h0);
        go(4'h7, 1'b1, 1'b1, 14'h0010, 18'h0_0000);
        chk(doe, 2'h3);
        chk(bus, 18'h1_2345);
        @(negedge mclk_i);
        oe_n = 1'b1;
        #1;
        chk(doe, 2'h0);
        oe_n = 1'b0;
        #1;
        chk(doe, 2'h3);
        @(posedge mclk_i);
        #1;
        // Deselected write is refused
        go(4'h6, 1'b0, 1'b0, 14'h0012, 18'h0_0055);
        chk(pd, 1'b1);
        go(4'h7, 1'b1, 1'b0, 14'h0012, 18'h0_0000);
        chk(doe, 2'h3);
        chk(bus, 18'h3_0002);
        // Lower lane only write, then lane gated read
        lanes_n = 2'h2;
        go(4'h6, 1'b1, 1'b0, 14'h0010, 18'h3_FFFF);
        chk(doe, 2'h0);
        go(4'h7, 1'b1, 1'b0, 14'h0010, 18'h0_0000);
        chk(doe, 2'h1);
        lanes_n = 2'h0;
        go(4'h7, 1'b1, 1'b0, 14'h0010, 18'h0_0000);
        chk(bus, 18'h1_23FF);
        // Park on a held read, then reset in mid-run
        go(4'hF, 1'b1, 1'b0, 14'h0000, 18'h0_0000);
        chk(bus, 18'h1_23FF);
        @(negedge mclk_i);
        srst_i = 1'b1;
        repeat (2) @(negedge mclk_i);
        chk(pd, 1'b1);
        chk(doe, 2'h0);
        srst_i = 1'b0;
        @(posedge mclk_i);
        #1;
        chk(bus, 18'h0_0ABC);
        go(4'hF, 1'b1, 1'b0, 14'h0000, 18'h0_0000);
        chk(bus, 18'h0_0ABC);
        go(4'hF, 1'b1, 1'b0, 14'h0000, 18'h0_0000);
        chk(doe, 2'h3);
        chk(bus, 18'h0_0ABC);
        end_sim();
    end
endmodule : sdp_port_test
